// ---- core/cmu_regs.svh ----
`ifndef CMU_REGS_SVH
`define CMU_REGS_SVH

// Number of instruction types the full core decodes; this unit handles a subset.
`define CMU_INSN_TYPES      62
// Register number of the 32-bit register that doubles as stack pointer.
`define CMU_SP_INDEX        3'h7
// Bit of a byte or word register code that selects lower byte or extended half.
`define CMU_CODE_HALF_BIT   3
// Packed decimal digit fields inside a byte.
`define CMU_BCD_UPPER_MSB   7
`define CMU_BCD_UPPER_LSB   4
`define CMU_BCD_LOWER_MSB   3
`define CMU_BCD_LOWER_LSB   0
// Largest legal decimal digit and the adjust steps.
`define CMU_BCD_MAX_DIGIT   4'h9
`define CMU_BCD_ADJ_LOW     8'h06
`define CMU_BCD_ADJ_HIGH    8'h60
`define CMU_BCD_MAX_BYTE    8'h99
// Byte distance from the upper word of a longword to its lower word.
`define CMU_WORD_STEP       2

`endif

// ---- core/cmu_pkg.sv ----
`default_nettype none

package cmu_pkg;

    // Operations accepted on the command port.
    typedef enum logic [3:0] {
        CMU_OP_MOVE_RR,
        CMU_OP_MOVE_LOAD,
        CMU_OP_MOVE_STORE,
        CMU_OP_MOVE_IMM,
        CMU_OP_PUSH,
        CMU_OP_POP,
        CMU_OP_BIT_SET,
        CMU_OP_BIT_CLR,
        CMU_OP_BIT_NOT,
        CMU_OP_BIT_TEST,
        CMU_OP_DECIMAL_ADJUST_ADD,
        CMU_OP_DECIMAL_ADJUST_SUB,
        CMU_OP_EXT_PERIPH_LOAD,
        CMU_OP_EXT_PERIPH_STORE
    } cmu_op_t;

    // Operand sizes.
    typedef enum logic [1:0] {
        CMU_SZ_BYTE,
        CMU_SZ_WORD,
        CMU_SZ_LONG
    } cmu_size_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        CMU_ST_IDLE,
        CMU_ST_ACCESS_FIRST,
        CMU_ST_ACCESS_SECOND
    } cmu_fsm_t;

endpackage : cmu_pkg

`default_nettype wire

// ---- core/cmu_move_unit.sv ----
// Function
// RULE1 - Operands of one bit, BCD digit, byte, word and longword are handled.
// RULE2 - Bit operations pick bit zero to seven of a byte and touch only it.
// RULE3 - Decimal adjust after add or subtract treats a byte as two digits.
// RULE4 - Upper digit sits in bits 7 to 4, lower digit in bits 3 to 0.
// RULE5 - Registers read as 16 bytes, 16 words or eight 32-bit address registers.
// RULE6 - Word and longword memory operands are placed at even byte addresses.
// RULE7 - Odd word or longword address raises no error; bit 0 is forced low.
// RULE8 - Instruction fetch addresses get the same bit 0 clearing, without error.
// RULE9 - Software should use only word or longword sizes on the stack.
// RULE10 - The full core provides 62 instruction types grouped by function.
// RULE11 - Move copies register, memory or immediate data in byte, word or longword.
// RULE12 - The two external peripheral byte moves are unsupported.
// RULE13 - Pop loads from the stack pointer, then adds the operand size to it.
// RULE14 - Push subtracts the operand size from the stack pointer, then stores.
// RULE15 - Multi-byte memory data is big-endian, most significant byte lowest.
`include "cmu_regs.svh"
`default_nettype none

module cmu_move_unit #(
    parameter int ADDR_W = 24
) (
    input  wire logic              mclk,          // Core clock.
    input  wire logic              arst_n,        // Asynchronous reset, active low.
    input  wire logic              cmd_valid,     // Command offered.
    input  wire cmu_pkg::cmu_op_t  cmd_op,        // Operation.
    input  wire cmu_pkg::cmu_size_t cmd_size,     // Operand size.
    input  wire logic [3:0]        cmd_dst,       // Destination register code.
    input  wire logic [3:0]        cmd_src,       // Source register code.
    input  wire logic [ADDR_W-1:0] cmd_addr,      // Memory operand address.
    input  wire logic [31:0]       cmd_imm,       // Immediate data.
    input  wire logic [2:0]        cmd_bit,       // Bit number for bit operations.
    input  wire logic              cmd_carry,     // Carry flag for decimal adjust.
    input  wire logic              cmd_half,      // Half-carry flag for decimal adjust.
    output logic                   cmd_ready,     // Unit idle, command may be taken.
    output logic                   cmd_done,      // Command finished, one cycle.
    output logic                   cmd_unsup,     // Unsupported command, one cycle.
    output logic                   bit_value,     // Tested bit value.
    output logic                   adj_carry,     // Carry out of decimal adjust.
    output logic                   mem_req,       // Memory access request.
    output logic                   mem_we,        // Memory write.
    output logic                   mem_byte,      // Byte access, else word.
    output logic [ADDR_W-1:0]      mem_addr,      // Memory byte address.
    output logic [15:0]            mem_wdata,     // Write data, byte in low bits.
    input  wire logic [15:0]       mem_rdata,     // Read data, byte in low bits.
    input  wire logic              mem_ack,       // Access completes this cycle.
    input  wire logic              fetch_req,     // Fetch address valid.
    input  wire logic [ADDR_W-1:0] fetch_addr_in, // Raw fetch address.
    output logic [ADDR_W-1:0]      fetch_addr,    // Aligned fetch address.
    input  wire logic [3:0]        rd_sel,        // Register view code.
    input  wire cmu_pkg::cmu_size_t rd_size,      // Register view size.
    output logic [31:0]            rd_data        // Register view data.
);

    // ADDR_W must lie between 2 and 32, and the op list must fit inside the core's instruction set.
    if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_addr
        $error("cmu_move_unit: ADDR_W must lie between 2 and 32.");
    end
    if (cmu_pkg::CMU_OP_EXT_PERIPH_STORE + 1 > `CMU_INSN_TYPES) begin : g_bad_ops // [RULE10]
        $error("cmu_move_unit: more operations than instruction types.");
    end

    typedef struct packed {
        cmu_pkg::cmu_fsm_t  state;
        logic [7:0][31:0]   regs;
        cmu_pkg::cmu_size_t size;
        logic [3:0]         dst;
        logic [31:0]        data;
        logic               idle;
        logic               done;
        logic               unsup;
        logic               bit_value;
        logic               adj_carry;
        logic               mem_req;
        logic               mem_we;
        logic               mem_byte;
        logic [ADDR_W-1:0]  mem_addr;
        logic [15:0]        mem_wdata;
        logic [ADDR_W-1:0]  fetch_addr;
        logic [31:0]        rd_data;
    } cmu_state_t;

    cmu_state_t q;
    cmu_state_t next_q;

    // Reads a register through the byte, word or longword view.
    function automatic logic [31:0] read_reg(logic [7:0][31:0] r, logic [3:0] code,
                                             cmu_pkg::cmu_size_t sz);
        logic [31:0] full;
        full = r[code[2:0]];
        case (sz)
            cmu_pkg::CMU_SZ_BYTE:
                read_reg = code[`CMU_CODE_HALF_BIT] ? {24'h0, full[7:0]}
                                                    : {24'h0, full[15:8]}; // [RULE5]
            cmu_pkg::CMU_SZ_WORD:
                read_reg = code[`CMU_CODE_HALF_BIT] ? {16'h0, full[31:16]}
                                                    : {16'h0, full[15:0]}; // [RULE5]
            default: read_reg = full; // [RULE5]
        endcase
    endfunction : read_reg

    // Writes a register view and leaves the other bits alone.
    function automatic logic [7:0][31:0] write_reg(logic [7:0][31:0] r, logic [3:0] code,
                                                   cmu_pkg::cmu_size_t sz, logic [31:0] v);
        logic [7:0][31:0] o;
        o = r;
        case (sz)
            cmu_pkg::CMU_SZ_BYTE:
                if (code[`CMU_CODE_HALF_BIT]) o[code[2:0]][7:0] = v[7:0]; // [RULE5]
                else o[code[2:0]][15:8] = v[7:0]; // [RULE5]
            cmu_pkg::CMU_SZ_WORD:
                if (code[`CMU_CODE_HALF_BIT]) o[code[2:0]][31:16] = v[15:0]; // [RULE5]
                else o[code[2:0]][15:0] = v[15:0]; // [RULE5]
            default: o[code[2:0]] = v; // [RULE5]
        endcase
        write_reg = o;
    endfunction : write_reg

    // Byte count of an operand size.
    function automatic logic [31:0] size_bytes(cmu_pkg::cmu_size_t sz);
        size_bytes = 32'h1 << sz; // Size codes 0, 1 and 2 give 1, 2 and 4 bytes.
    endfunction : size_bytes

    // Forces bit 0 low so a multi-byte access starts at the even byte, never faulting.
    function automatic logic [ADDR_W-1:0] align(logic [ADDR_W-1:0] a);
        align = {a[ADDR_W-1:1], 1'b0}; // [RULE7] [RULE6]
    endfunction : align

    // Decimal adjust of two packed digits; returns carry out above the byte.
    function automatic logic [8:0] dec_adjust(logic [7:0] v, logic c, logic h, logic sub);
        logic [3:0] upper;
        logic [3:0] lower;
        logic [7:0] adj;
        logic       cout;
        upper = v[`CMU_BCD_UPPER_MSB:`CMU_BCD_UPPER_LSB]; // [RULE4]
        lower = v[`CMU_BCD_LOWER_MSB:`CMU_BCD_LOWER_LSB]; // [RULE4]
        adj   = 8'h00;
        cout  = c;
        if (sub) begin
            if (h) adj = adj + `CMU_BCD_ADJ_LOW;
            if (c) adj = adj + `CMU_BCD_ADJ_HIGH;
            dec_adjust = {cout, v - adj}; // [RULE3]
        end else begin
            if (h || lower > `CMU_BCD_MAX_DIGIT) adj = adj + `CMU_BCD_ADJ_LOW;
            if (c || v > `CMU_BCD_MAX_BYTE || upper > `CMU_BCD_MAX_DIGIT) begin
                adj  = adj + `CMU_BCD_ADJ_HIGH;
                cout = 1'b1;
            end
            dec_adjust = {cout, v + adj}; // [RULE3]
        end
    endfunction : dec_adjust

    // Next-state logic: one command in flight, memory through a request/ack handshake.
    always_comb begin
        logic [31:0] src_val;
        logic [31:0] sp_val;
        logic [7:0]  byte_val;
        logic [8:0]  adj;
        next_q       = q;
        src_val      = read_reg(q.regs, cmd_src, cmd_size);
        sp_val       = q.regs[`CMU_SP_INDEX];
        byte_val     = 8'(read_reg(q.regs, cmd_dst, cmu_pkg::CMU_SZ_BYTE));
        adj          = dec_adjust(byte_val, cmd_carry, cmd_half,
                                  cmd_op == cmu_pkg::CMU_OP_DECIMAL_ADJUST_SUB);
        next_q.done  = 1'b0;
        next_q.unsup = 1'b0;
        next_q.rd_data = read_reg(q.regs, rd_sel, rd_size);
        if (fetch_req) next_q.fetch_addr = align(fetch_addr_in); // [RULE8]
        case (q.state)
            cmu_pkg::CMU_ST_IDLE: begin
                if (cmd_valid) begin
                    next_q.size = cmd_size;
                    next_q.dst  = cmd_dst;
                    next_q.done = 1'b1;
                    case (cmd_op)
                        cmu_pkg::CMU_OP_MOVE_RR: begin
                            next_q.regs = write_reg(q.regs, cmd_dst, cmd_size, src_val); // [RULE11]
                        end
                        cmu_pkg::CMU_OP_MOVE_IMM: begin
                            next_q.regs = write_reg(q.regs, cmd_dst, cmd_size, cmd_imm); // [RULE11]
                        end
                        cmu_pkg::CMU_OP_MOVE_LOAD, cmu_pkg::CMU_OP_MOVE_STORE,
                        cmu_pkg::CMU_OP_PUSH, cmu_pkg::CMU_OP_POP: begin
                            next_q.done     = 1'b0;
                            next_q.idle     = 1'b0;
                            next_q.state    = cmu_pkg::CMU_ST_ACCESS_FIRST;
                            next_q.mem_req  = 1'b1;
                            next_q.mem_byte = (cmd_size == cmu_pkg::CMU_SZ_BYTE);
                            next_q.mem_we   = (cmd_op == cmu_pkg::CMU_OP_MOVE_STORE) ||
                                              (cmd_op == cmu_pkg::CMU_OP_PUSH); // [RULE11]
                            next_q.data     = src_val;
                            next_q.mem_addr = cmd_addr;
                            if (cmd_op == cmu_pkg::CMU_OP_PUSH) begin
                                sp_val = sp_val - size_bytes(cmd_size); // [RULE14]
                                next_q.regs[`CMU_SP_INDEX] = sp_val; // [RULE14]
                                next_q.mem_addr = sp_val[ADDR_W-1:0]; // [RULE14]
                            end else if (cmd_op == cmu_pkg::CMU_OP_POP) begin
                                next_q.mem_addr = sp_val[ADDR_W-1:0]; // [RULE13]
                                // Loaded data lands later and so wins over the increment.
                                next_q.regs[`CMU_SP_INDEX] = sp_val + size_bytes(cmd_size); // [RULE13]
                            end
                            if (cmd_size != cmu_pkg::CMU_SZ_BYTE) begin
                                next_q.mem_addr = align(next_q.mem_addr); // [RULE7] [RULE6]
                            end
                            // Big-endian: the upper half goes out first at the even address.
                            next_q.mem_wdata = (cmd_size == cmu_pkg::CMU_SZ_LONG) ?
                                               src_val[31:16] : src_val[15:0]; // [RULE15]
                        end
                        cmu_pkg::CMU_OP_BIT_SET, cmu_pkg::CMU_OP_BIT_CLR,
                        cmu_pkg::CMU_OP_BIT_NOT: begin
                            byte_val[cmd_bit] = (cmd_op == cmu_pkg::CMU_OP_BIT_SET) ||
                                (cmd_op == cmu_pkg::CMU_OP_BIT_NOT && !byte_val[cmd_bit]); // [RULE2]
                            next_q.regs = write_reg(q.regs, cmd_dst, cmu_pkg::CMU_SZ_BYTE,
                                                    {24'h0, byte_val}); // [RULE1]
                        end
                        cmu_pkg::CMU_OP_BIT_TEST: begin
                            next_q.bit_value = byte_val[cmd_bit]; // [RULE2] [RULE1]
                        end
                        cmu_pkg::CMU_OP_DECIMAL_ADJUST_ADD, cmu_pkg::CMU_OP_DECIMAL_ADJUST_SUB: begin
                            next_q.adj_carry = adj[8];
                            next_q.regs = write_reg(q.regs, cmd_dst, cmu_pkg::CMU_SZ_BYTE,
                                                    {24'h0, adj[7:0]}); // [RULE3] [RULE1]
                        end
                        default: begin
                            // External peripheral moves change nothing and are flagged.
                            next_q.unsup = 1'b1; // [RULE12]
                        end
                    endcase
                end
            end
            cmu_pkg::CMU_ST_ACCESS_FIRST: begin
                if (mem_ack) begin
                    if (q.size == cmu_pkg::CMU_SZ_LONG) begin
                        next_q.state     = cmu_pkg::CMU_ST_ACCESS_SECOND;
                        if (!q.mem_we) next_q.data[31:16] = mem_rdata; // [RULE15]
                        next_q.mem_addr  = q.mem_addr + ADDR_W'(`CMU_WORD_STEP); // [RULE15]
                        next_q.mem_wdata = q.data[15:0]; // [RULE15]
                    end else begin
                        next_q.state   = cmu_pkg::CMU_ST_IDLE;
                        next_q.mem_req = 1'b0;
                        next_q.idle    = 1'b1;
                        next_q.done    = 1'b1;
                        if (!q.mem_we) begin
                            next_q.regs = write_reg(q.regs, q.dst, q.size,
                                                    {16'h0, mem_rdata}); // [RULE11]
                        end
                    end
                end
            end
            cmu_pkg::CMU_ST_ACCESS_SECOND: begin
                if (mem_ack) begin
                    next_q.state   = cmu_pkg::CMU_ST_IDLE;
                    next_q.mem_req = 1'b0;
                    next_q.idle    = 1'b1;
                    next_q.done    = 1'b1;
                    if (!q.mem_we) begin
                        next_q.regs = write_reg(q.regs, q.dst, q.size,
                                                {q.data[31:16], mem_rdata}); // [RULE15]
                    end
                end
            end
            default: next_q.state = cmu_pkg::CMU_ST_IDLE;
        endcase
    end

    // State register; all clears under reset but the ready flag, so commands follow at once.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.idle <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from state flops.
    assign cmd_ready  = q.idle;
    assign cmd_done   = q.done;
    assign cmd_unsup  = q.unsup;
    assign bit_value  = q.bit_value;
    assign adj_carry  = q.adj_carry;
    assign mem_req    = q.mem_req;
    assign mem_we     = q.mem_we;
    assign mem_byte   = q.mem_byte;
    assign mem_addr   = q.mem_addr;
    assign mem_wdata  = q.mem_wdata;
    assign fetch_addr = q.fetch_addr;
    assign rd_data    = q.rd_data;

endmodule : cmu_move_unit

`default_nettype wire

// ---- tb/cmu_move_props.sv ----
`default_nettype none

module cmu_move_props #(
    parameter int ADDR_W = 24
) (
    input wire logic               mclk,          // Clock.
    input wire logic               arst_n,        // Reset.
    input wire logic               cmd_valid,     // Offer.
    input wire cmu_pkg::cmu_op_t   cmd_op,        // Operation.
    input wire logic               cmd_ready,     // Idle.
    input wire logic               cmd_done,      // Done.
    input wire logic               cmd_unsup,     // Unsupported.
    input wire logic               mem_req,       // Request.
    input wire logic               mem_we,        // Write.
    input wire logic               mem_byte,      // Byte.
    input wire logic [ADDR_W-1:0]  mem_addr,      // Address.
    input wire logic               mem_ack,       // Ack.
    input wire logic               fetch_req,     // Fetch valid.
    input wire logic [ADDR_W-1:0]  fetch_addr_in, // Raw fetch.
    input wire logic [ADDR_W-1:0]  fetch_addr     // Aligned fetch.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Command classes at the taking edge.
    logic take, ext_op, mem_op;
    assign take = cmd_valid && cmd_ready;
    assign ext_op = cmd_op inside {cmu_pkg::CMU_OP_EXT_PERIPH_LOAD,
                                   cmu_pkg::CMU_OP_EXT_PERIPH_STORE};
    assign mem_op = cmd_op inside {cmu_pkg::CMU_OP_MOVE_LOAD, cmu_pkg::CMU_OP_MOVE_STORE,
                                   cmu_pkg::CMU_OP_PUSH, cmu_pkg::CMU_OP_POP};

    a_word_even_addr: assert property (mem_req && !mem_byte |-> !mem_addr[0])
        else $error("word access at odd address");
    a_fetch_bit_clear: assert property (fetch_req |=>
        fetch_addr == {$past(fetch_addr_in[ADDR_W-1:1]), 1'b0})
        else $error("fetch address not aligned");
    a_long_next_word: assert property (mem_req && mem_ack ##1 mem_req |->
        mem_addr == $past(mem_addr) + ADDR_W'(2))
        else $error("second half not at address plus two");
    a_ext_refused: assert property (take && ext_op |=> cmd_unsup && cmd_done && !mem_req)
        else $error("external move not refused");
    a_unsup_only_ext: assert property (cmd_unsup |-> $past(take && ext_op))
        else $error("spurious unsupported pulse");
    a_push_stores: assert property (take && cmd_op == cmu_pkg::CMU_OP_PUSH |=> mem_req && mem_we)
        else $error("push did not start a store");
    a_pop_loads: assert property (take && cmd_op == cmu_pkg::CMU_OP_POP |=> mem_req && !mem_we)
        else $error("pop did not start a load");
    a_reg_op_fast: assert property (take && !mem_op && !ext_op |=> cmd_done && !mem_req)
        else $error("register operation not done in one cycle");
    a_mem_op_done: assert property (mem_req && mem_ack ##1 !mem_req |-> cmd_done)
        else $error("memory operation end without done");
endmodule : cmu_move_props

bind cmu_move_unit cmu_move_props #(.ADDR_W(ADDR_W)) u_props (.*);

`default_nettype wire

// ---- tb/cmu_mem_model.sv ----
`default_nettype none

module cmu_mem_model #(
    parameter int ADDR_W = 24
) (
    input wire logic              mclk,      // Clock.
    input wire logic              arst_n,    // Reset.
    input wire logic              mem_req,   // Request.
    input wire logic              mem_we,    // Write.
    input wire logic              mem_byte,  // Byte access.
    input wire logic [ADDR_W-1:0] mem_addr,  // Address.
    input wire logic [15:0]       mem_wdata, // Write data.
    input wire logic [3:0]        slow,      // Wait cycles.
    output logic                  mem_ack,   // Ack.
    output logic [15:0]           mem_rdata  // Read data.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [3:0] wait_cnt;
    logic [7:0] a;
    assign a = mem_addr[7:0];

    // Read data is inverted after the ack, so a late sample sees junk.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata <= 16'h0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && wait_cnt < slow) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else if (mem_req) begin
            mem_ack <= 1'b1;
            wait_cnt <= 4'h0;
            if (mem_byte) begin
                if (mem_we) mem[a] <= mem_wdata[7:0];
                mem_rdata <= {8'h0, mem[a]};
            end else begin
                // Words are taken at the even address given, high byte first.
                if (mem_we) mem[a] <= mem_wdata[15:8];
                if (mem_we) mem[a+8'h1] <= mem_wdata[7:0];
                mem_rdata <= {mem[a], mem[a+8'h1]};
            end
        end
    end
endmodule : cmu_mem_model

`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 24;
    localparam cmu_pkg::cmu_size_t sz_b = cmu_pkg::CMU_SZ_BYTE;
    localparam cmu_pkg::cmu_size_t sz_w = cmu_pkg::CMU_SZ_WORD;
    localparam cmu_pkg::cmu_size_t sz_l = cmu_pkg::CMU_SZ_LONG;
    logic               mclk, arst_n, cmd_valid, cmd_carry, cmd_half, fetch_req;
    logic               cmd_ready, cmd_done, cmd_unsup, bit_value, adj_carry, rd_chk, chk_d;
    logic               mem_req, mem_we, mem_byte, mem_ack, u;
    cmu_pkg::cmu_op_t   cmd_op;
    cmu_pkg::cmu_size_t cmd_size, rd_size;
    logic [3:0]         cmd_dst, cmd_src, rd_sel, slow;
    logic [AW-1:0]      cmd_addr, mem_addr, fetch_addr_in, fetch_addr;
    logic [31:0]        cmd_imm, rd_data, rng, r1;
    logic [2:0]         cmd_bit;
    logic [15:0]        mem_wdata, mem_rdata;
    logic [7:0]         b;
    logic [31:0]        rv [8];
    logic [31:0]        q [$];
    logic [19:0]        tab [5] = '{20'h00a10, 20'h19a00, 20'h23238, 20'ha1b15, 20'hdf090};
    int                 err_count, n_compared;

    cmu_move_unit #(.ADDR_W(AW)) dut (.*);
    cmu_mem_model #(.ADDR_W(AW)) m (.*);

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // The view answers one edge late, so each note is matched a falling edge on.
    always @(posedge mclk) chk_d <= rd_chk;
    always @(negedge mclk) begin
        if (chk_d) chk("rd_data", q.pop_front(), rd_data);
    end

    task automatic view(input logic [3:0] s, input cmu_pkg::cmu_size_t z, input logic [31:0] e);
        @(negedge mclk);
        rd_sel = s;
        rd_size = z;
        rd_chk = 1'b1;
        q.push_back(e);
        @(negedge mclk);
        rd_chk = 1'b0;
    endtask : view

    // One command; v carries address, immediate and bit number alike.
    task automatic run(input cmu_pkg::cmu_op_t o, input cmu_pkg::cmu_size_t z,
                       input logic [3:0] d, input logic [3:0] s, input logic [31:0] v);
        @(negedge mclk);
        cmd_op = o;
        cmd_size = z;
        cmd_dst = d;
        cmd_src = s;
        cmd_addr = v[AW-1:0];
        cmd_imm = v;
        cmd_bit = v[2:0];
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        repeat (60) begin
            if (cmd_done === 1'b1) break;
            @(negedge mclk);
        end
        u = cmd_unsup;
        if (cmd_done !== 1'b1) begin
            $display("[ERR] cmd_done expected 1 seen %b", cmd_done);
            err_count++;
            print_verdict();
        end
    endtask : run

    initial begin
        {arst_n, cmd_valid, cmd_carry, cmd_half, fetch_req, rd_chk} = 6'h0;
        {cmd_dst, cmd_src, rd_sel, slow, cmd_bit} = 19'h0;
        {cmd_addr, fetch_addr_in, cmd_imm} = 80'h0;
        cmd_op = cmu_pkg::CMU_OP_MOVE_RR;
        cmd_size = sz_b;
        rd_size = sz_l;
        err_count = 0;
        n_compared = 0;
        rng = 32'hc;
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        chk("cmd_ready", 32'h1, 32'(cmd_ready));
        for (int r = 0; r < 8; r++) begin
            rng = xs(rng);
            rv[r] = (r == 7) ? 32'h100 : rng;
            run(cmu_pkg::CMU_OP_MOVE_IMM, sz_l, 4'(r), 4'h0, rv[r]);
            view(4'(r), sz_l, rv[r]);
        end
        r1 = rv[1];
        view(4'h1, sz_w, {16'h0, r1[15:0]});
        view(4'h9, sz_w, {16'h0, r1[31:16]});
        view(4'h1, sz_b, {24'h0, r1[15:8]});
        view(4'h9, sz_b, {24'h0, r1[7:0]});
        run(cmu_pkg::CMU_OP_MOVE_RR, sz_b, 4'ha, 4'h1, 32'h0);
        view(4'h2, sz_l, {rv[2][31:8], r1[15:8]});
        $display("done: register views");
        b = rv[3][7:0];
        for (int k = 0; k < 16; k++) begin
            run(cmu_pkg::cmu_op_t'(cmu_pkg::CMU_OP_BIT_SET + 4'(k % 4)), sz_b, 4'hb, 4'h0, 32'(k));
            case (k % 4)
                0: b[k%8] = 1'b1;
                1: b[k%8] = 1'b0;
                2: b[k%8] = ~b[k%8];
                default: chk("bit_value", 32'(b[k%8]), 32'(bit_value));
            endcase
            view(4'h3, sz_l, {rv[3][31:8], b});
        end
        $display("done: bit operations");
        for (int e = 0; e < 5; e++) begin
            {cmd_carry, cmd_half} = tab[e][18:17];
            run(cmu_pkg::CMU_OP_MOVE_IMM, sz_b, {~e[0], 3'h4}, 4'h0, 32'(tab[e][15:8]));
            run(tab[e][19] ? cmu_pkg::CMU_OP_DECIMAL_ADJUST_SUB : cmu_pkg::CMU_OP_DECIMAL_ADJUST_ADD,
                sz_b, {~e[0], 3'h4}, 4'h0, 32'h0);
            view({~e[0], 3'h4}, sz_b, 32'(tab[e][7:0]));
            chk("adj_carry", 32'(tab[e][16]), 32'(adj_carry));
        end
        $display("done: decimal adjust");
        slow = 4'h3;
        run(cmu_pkg::CMU_OP_MOVE_STORE, sz_w, 4'h0, 4'h1, 32'h11);
        chk("mem10", 32'(r1[15:8]), 32'(m.mem[8'h10]));
        chk("mem11", 32'(r1[7:0]), 32'(m.mem[8'h11]));
        run(cmu_pkg::CMU_OP_MOVE_STORE, sz_l, 4'h0, 4'h1, 32'h21);
        slow = 4'h0;
        run(cmu_pkg::CMU_OP_MOVE_LOAD, sz_l, 4'h5, 4'h0, 32'h21);
        view(4'h5, sz_l, r1);
        run(cmu_pkg::CMU_OP_MOVE_STORE, sz_b, 4'h0, 4'h9, 32'h31);
        chk("mem31", 32'(r1[7:0]), 32'(m.mem[8'h31]));
        run(cmu_pkg::CMU_OP_MOVE_LOAD, sz_b, 4'h5, 4'h0, 32'h31);
        view(4'h5, sz_l, {r1[31:16], r1[7:0], r1[7:0]});
        $display("done: memory moves");
        slow = 4'h1;
        run(cmu_pkg::CMU_OP_PUSH, sz_l, 4'h0, 4'h1, 32'h0);
        view(4'h7, sz_l, 32'hfc);
        chk("memfc", 32'(r1[31:24]), 32'(m.mem[8'hfc]));
        chk("memff", 32'(r1[7:0]), 32'(m.mem[8'hff]));
        run(cmu_pkg::CMU_OP_POP, sz_w, 4'h6, 4'h0, 32'h0);
        view(4'h7, sz_l, 32'hfe);
        view(4'h6, sz_l, {rv[6][31:16], r1[31:16]});
        $display("done: stack");
        for (int e = 0; e < 2; e++) begin
            run(cmu_pkg::cmu_op_t'(cmu_pkg::CMU_OP_EXT_PERIPH_LOAD + 4'(e)), sz_b, 4'h8, 4'h8, 32'h40);
            chk("cmd_unsup", 32'h1, 32'(u));
            view(4'h0, sz_l, rv[0]);
        end
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            @(negedge mclk);
            fetch_req = 1'b1;
            fetch_addr_in = rng[AW-1:0];
            @(negedge mclk);
            fetch_req = 1'b0;
            chk("fetch_addr", 32'({rng[AW-1:1], 1'b0}), 32'(fetch_addr));
        end
        $display("done: refusals and fetch");
        repeat (3) @(negedge mclk);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
